// >>> rtl/wdt_consts.svh
// timing counts, reset values and field constants of the watchdog timer
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_MC_DIV 12
`define WDT_DIV_FAST 2
`define WDT_DIV_SLOW 128
`define WDT_REF_MC 3
`define WDT_RST_LEN 16
`define WDT_RST_BYTE 8'h00
`define WDT_RST_COUNT 16'h0000
`define WDT_LOW_START 8'h00
`define WDT_COUNT_MAX 16'hffff
`define WDT_SEEN_ONE 2'h1
`define WDT_SEEN_MAX 2'h3

`endif

// >>> rtl/wdt_pkg.sv
// types shared by the watchdog timer modules
package wdt_pkg;
  typedef logic [7:0] wdt_byte_t;
  typedef logic [15:0] wdt_count_t;
  typedef logic [1:0] wdt_seen_t;
endpackage : wdt_pkg

// >>> rtl/wdt_presc_if.sv
// link between the watchdog core and its prescaler
`timescale 1ns/1ps
interface wdt_presc_if;
  logic run;
  logic clear;
  logic sel;
  logic mcTick;
  logic cntTick;
  modport core (output run, output clear, output sel, input mcTick, input cntTick);
  modport presc (input run, input clear, input sel, output mcTick, output cntTick);
endinterface : wdt_presc_if

// >>> rtl/wdt_prescaler.sv
// machine-cycle divider and selectable count prescaler
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int MC_DIV = `WDT_MC_DIV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic powerDown,
  wdt_presc_if.presc pi
);
  localparam int MCW = $clog2(MC_DIV);
  localparam logic [6:0] LIM_FAST = 7'(`WDT_DIV_FAST - 1);
  localparam logic [6:0] LIM_SLOW = 7'(`WDT_DIV_SLOW - 1);

  logic [MCW-1:0] mcCnt_q;
  logic [6:0] divCnt_q;
  logic [6:0] divLim;

  generate
    if (MC_DIV < 2) begin : g_chk
      $error("MC_DIV must be at least 2");
    end
  endgenerate

  // whole clock tree stops in power-down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcCnt_q <= '0;
    end else if (!powerDown) begin
      if (mcCnt_q == MCW'(MC_DIV - 1)) begin
        mcCnt_q <= '0;
      end else begin
        mcCnt_q <= mcCnt_q + 1'b1;
      end
    end
  end

  assign pi.mcTick = !powerDown && (mcCnt_q == MCW'(MC_DIV - 1)); // RULE2

  assign divLim = pi.sel ? LIM_SLOW : LIM_FAST; // RULE2 RULE16

  // frozen state is kept, so a pause does not lose partial prescale
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
    end else if (pi.clear) begin
      divCnt_q <= '0;
    end else if (pi.run && pi.mcTick) begin
      if (divCnt_q >= divLim) begin
        divCnt_q <= '0;
      end else begin
        divCnt_q <= divCnt_q + 1'b1;
      end
    end
  end

  assign pi.cntTick = pi.run && pi.mcTick && (divCnt_q >= divLim);
endmodule : wdt_prescaler

// >>> rtl/wdt_watchdog_timer.sv
// watchdog timer with general-purpose timer mode
//
// Overview of operation
// RULE1: sixteen-bit up counter clocked through a selectable prescaler
// RULE2: input clock is sys_clk/12; select picks divide-by-2 or divide-by-128
// RULE3: count readable as high and low byte; no software write path
// RULE4: start in watchdog mode loads reload into high byte, clears low, next clock
// RULE5: reload writable anytime; reaches counter on start, refresh or retained reset
// RULE6: started watchdog cannot be stopped; mode writes ignored while running
// RULE7: refresh counts only if the very next instruction sets start
// RULE8: refresh bit self-clears after three machine cycles
// RULE9: accepted refresh clears low byte and loads reload into high byte
// RULE10: watchdog-mode overflow without refresh raises internal system reset
// RULE11: normal reset clears all control bits and the counter
// RULE12: watchdog reset keeps start and retain bits, sets reset-source flag
// RULE13: retain keeps reload and prescaler; otherwise both cleared
// RULE14: off in power-down; idle freezes watchdog mode, timer mode runs
// RULE15: power-save ignored in watchdog mode; freezes timer mode
// RULE16: interval is prescale times (65536 minus reload times 256) input clocks
// RULE17: timer mode selectable only before watchdog start
// RULE18: timer start clears overflow flag, loads reload, counts up
// RULE19: timer overflow sets flag and interrupt source, no reset; irq if enabled
// RULE20: timer reloads after overflow; clearing run bit stops it
// RULE21: mode change ignored while timer runs unless same write stops it
// RULE22: reload register doubles as scratch register in timer mode
// RULE23: overflow is a one-cycle event when counter leaves all ones
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int MC_DIV = `WDT_MC_DIV,
  parameter int RST_LEN = `WDT_RST_LEN
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reloadWr,
  input wire logic [7:0] reloadWrData,
  input wire logic ctrlWr,
  input wire logic ctrlWrStart,
  input wire logic ctrlWrPresc,
  input wire logic ctrlWrRetain,
  input wire logic ctrlWrTimerMode,
  input wire logic ctrlWrTimerRun,
  input wire logic refreshWr,
  input wire logic instrDone,
  input wire logic ovfFlagClr,
  input wire logic intSrcClr,
  input wire logic timerInterruptEnable,
  input wire logic idleMode,
  input wire logic powerDown,
  input wire logic peripheralPowerSave,
  output logic [7:0] countHigh,
  output logic [7:0] countLow,
  output logic [7:0] reloadValue,
  output logic prescSel,
  output logic retainConfigBit,
  output logic startBit,
  output logic timerMode,
  output logic timerRunBit,
  output logic refreshBit,
  output logic resetSrcFlag,
  output logic timerOverflowFlag,
  output logic interruptSourceBit,
  output logic wdtSysReset,
  output logic timerIrq
);
  localparam int RCW = $clog2(RST_LEN + 1);
  localparam int REF_BOUND = MC_DIV * `WDT_REF_MC + 1;

  generate
    if (RST_LEN < 1) begin : g_chk
      $error("RST_LEN must be at least 1");
    end
  endgenerate

  wdt_presc_if pi ();

  wdt_count_t count_q;
  wdt_byte_t reload_q;
  logic prescSel_q;
  logic retain_q;
  logic start_q;
  logic timerMode_q;
  logic timerRun_q;
  logic refresh_q;
  logic [1:0] refMc_q;
  wdt_seen_t instrSeen_q;
  logic loadPend_q;
  logic resetSrc_q;
  logic ovfFlag_q;
  logic intSrc_q;
  logic rstActive_q;
  logic [RCW-1:0] rstCnt_q;

  logic wdRunning;
  logic startReq;
  logic firstStart;
  logic refreshOk;
  logic modeChgOk;
  logic nextMode;
  logic timerStartEv;
  logic ovf;
  logic wdOverflow;
  logic tmrOverflow;

  function automatic wdt_count_t loadValue(input wdt_byte_t rel);
    loadValue = {rel, `WDT_LOW_START};
  endfunction : loadValue

  wdt_prescaler #(
    .MC_DIV(MC_DIV)
  ) u_presc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .powerDown(powerDown),
    .pi(pi)
  );

  assign wdRunning = start_q && !timerMode_q;
  assign startReq = ctrlWr && ctrlWrStart && !timerMode_q;
  assign firstStart = startReq && !start_q;
  // refresh bit set and exactly one instruction boundary since its write
  assign refreshOk = startReq && start_q && refresh_q && (instrSeen_q == `WDT_SEEN_ONE); // RULE7
  // mode bit locked once watchdog runs, and while timer runs unless stopped together
  assign modeChgOk = !start_q && !firstStart && (!timerRun_q || !ctrlWrTimerRun); // RULE6 RULE17 RULE21
  assign nextMode = (ctrlWr && modeChgOk) ? ctrlWrTimerMode : timerMode_q;
  assign timerStartEv = ctrlWr && ctrlWrTimerRun && !timerRun_q && nextMode; // RULE18

  // idle freezes watchdog mode only; power-save freezes timer mode only
  assign pi.run = !powerDown && ((wdRunning && !idleMode && !loadPend_q && !rstActive_q) ||
                                 (timerMode_q && timerRun_q && !peripheralPowerSave)); // RULE14 RULE15
  assign pi.sel = prescSel_q;
  assign pi.clear = loadPend_q || timerStartEv || ovf;

  assign ovf = pi.cntTick && (count_q == `WDT_COUNT_MAX); // RULE23
  assign wdOverflow = ovf && wdRunning; // RULE10
  assign tmrOverflow = ovf && timerMode_q && timerRun_q; // RULE19

  // counter has no software write port at all
  always_ff @(posedge sys_clk or negedge rst_n) begin // RULE3
    if (!rst_n) begin
      count_q <= `WDT_RST_COUNT; // RULE11
    end else if (loadPend_q) begin
      count_q <= loadValue(reload_q); // RULE4 RULE9
    end else if (wdOverflow) begin
      count_q <= loadValue(retain_q ? reload_q : `WDT_RST_BYTE); // RULE13
    end else if (tmrOverflow || timerStartEv) begin
      count_q <= loadValue(reload_q); // RULE18 RULE20
    end else if (pi.cntTick) begin
      count_q <= count_q + 1'b1; // RULE1
    end
  end

  // load one clock after the accepted start or refresh write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadPend_q <= 1'b0;
    end else begin
      loadPend_q <= firstStart || refreshOk; // RULE4 RULE5
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= `WDT_RST_BYTE; // RULE11
    end else if (wdOverflow && !retain_q) begin
      reload_q <= `WDT_RST_BYTE; // RULE13
    end else if (reloadWr) begin
      reload_q <= reloadWrData; // RULE5 RULE22
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescSel_q <= 1'b0;
    end else if (wdOverflow && !retain_q) begin
      prescSel_q <= 1'b0; // RULE13
    end else if (ctrlWr) begin
      prescSel_q <= ctrlWrPresc; // RULE2
    end
  end

  // a watchdog reset leaves retain and start untouched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      retain_q <= 1'b0;
    end else if (ctrlWr) begin
      retain_q <= ctrlWrRetain; // RULE12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0; // RULE11
    end else if (firstStart) begin
      start_q <= 1'b1; // RULE6 RULE12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerMode_q <= 1'b0;
    end else begin
      timerMode_q <= nextMode; // RULE17 RULE21
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerRun_q <= 1'b0;
    end else if (ctrlWr) begin
      timerRun_q <= ctrlWrTimerRun && nextMode; // RULE20
    end
  end

  // a new write restarts the three machine cycle window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_q <= 1'b0;
      refMc_q <= '0;
    end else if (refreshWr) begin
      refresh_q <= 1'b1;
      refMc_q <= '0;
    end else if (refreshOk || wdOverflow) begin
      refresh_q <= 1'b0;
      refMc_q <= '0;
    end else if (refresh_q && pi.mcTick) begin
      if (refMc_q == 2'(`WDT_REF_MC - 1)) begin
        refresh_q <= 1'b0; // RULE8
        refMc_q <= '0;
      end else begin
        refMc_q <= refMc_q + 1'b1;
      end
    end
  end

  // the refreshing instruction itself ends at the first boundary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instrSeen_q <= '0;
    end else if (refreshWr) begin
      instrSeen_q <= instrDone ? `WDT_SEEN_ONE : 2'h0; // RULE7
    end else if (instrDone && instrSeen_q != `WDT_SEEN_MAX) begin
      instrSeen_q <= instrSeen_q + 1'b1; // RULE7
    end
  end

  // read-only source flag, only a normal reset clears it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetSrc_q <= 1'b0;
    end else if (wdOverflow) begin
      resetSrc_q <= 1'b1; // RULE12
    end
  end

  // reset pulse drives the system reset and pauses watchdog counting, clock generation is not touched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstActive_q <= 1'b0;
      rstCnt_q <= '0;
    end else if (wdOverflow) begin
      rstActive_q <= 1'b1; // RULE10 RULE12
      rstCnt_q <= RCW'(RST_LEN - 1);
    end else if (rstActive_q) begin
      if (rstCnt_q == '0) begin
        rstActive_q <= 1'b0;
      end else begin
        rstCnt_q <= rstCnt_q - 1'b1;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag_q <= 1'b0;
    end else if (tmrOverflow) begin
      ovfFlag_q <= 1'b1; // RULE19
    end else if (timerStartEv || ovfFlagClr) begin
      ovfFlag_q <= 1'b0; // RULE18
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intSrc_q <= 1'b0;
    end else if (tmrOverflow) begin
      intSrc_q <= 1'b1; // RULE19
    end else if (intSrcClr) begin
      intSrc_q <= 1'b0;
    end
  end

  assign countHigh = count_q[15:8];
  assign countLow = count_q[7:0];
  assign reloadValue = reload_q;
  assign prescSel = prescSel_q;
  assign retainConfigBit = retain_q;
  assign startBit = start_q;
  assign timerMode = timerMode_q;
  assign timerRunBit = timerRun_q;
  assign refreshBit = refresh_q;
  assign resetSrcFlag = resetSrc_q;
  assign timerOverflowFlag = ovfFlag_q;
  assign interruptSourceBit = intSrc_q;
  assign wdtSysReset = rstActive_q;
  assign timerIrq = intSrc_q && timerInterruptEnable; // RULE19

  AST_START_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
    firstStart |=> ##1 (countLow == `WDT_LOW_START && countHigh == $past(reloadValue)))
    else $error("start did not load the counter one clock later");

  AST_START_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
    startBit |=> startBit)
    else $error("watchdog start bit dropped");

  AST_MODE_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE17
    (startBit && !timerMode) |=> !timerMode)
    else $error("timer mode entered after watchdog start");

  AST_REF_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
    (refreshBit && !powerDown) |-> ##[1:REF_BOUND] (!refreshBit || refreshWr || powerDown))
    else $error("refresh bit not cleared within three machine cycles");

  AST_REFRESH_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
    refreshOk |=> ##1 (countLow == `WDT_LOW_START && countHigh == $past(reloadValue)))
    else $error("refresh did not reload the counter");

  AST_REF_SEQ: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
    (startReq && startBit && instrSeen_q != `WDT_SEEN_ONE) |=> !loadPend_q)
    else $error("refresh accepted with wrong instruction spacing");

  AST_WD_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
    wdOverflow |=> (wdtSysReset && resetSrcFlag && startBit) [*1] ##1 wdtSysReset || (RST_LEN == 1))
    else $error("overflow did not raise watchdog reset");

  AST_NO_RETAIN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE13
    (wdOverflow && !retainConfigBit) |=> (reloadValue == `WDT_RST_BYTE && !prescSel && count_q == `WDT_RST_COUNT))
    else $error("watchdog reset without retain kept configuration");

  AST_IDLE_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE14
    (idleMode && !timerMode && !loadPend_q) |=> $stable(count_q))
    else $error("watchdog counted in idle");

  AST_PERIPHERAL_POWER_SAVE_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE15
    (timerMode && peripheralPowerSave && !timerStartEv) |=> $stable(count_q))
    else $error("timer counted under power save");

  AST_TMR_OVF: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE19
    tmrOverflow |=> (timerOverflowFlag && interruptSourceBit && !wdtSysReset && $stable(resetSrcFlag)))
    else $error("timer overflow handled wrongly");

  AST_TMR_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE20
    tmrOverflow |=> (count_q == {$past(reloadValue), `WDT_LOW_START}))
    else $error("timer did not reload after overflow");

  AST_OVF_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE23
    ovf |=> !ovf)
    else $error("overflow lasted more than one cycle");
endmodule : wdt_watchdog_timer

// >>> verif/wdt_watchdog_timer_tb.sv
// self-checking bench for the watchdog timer with timer mode
`timescale 1ns/1ps
module wdt_watchdog_timer_tb
  import wdt_pkg::*;
();
  // short machine cycle keeps overflow runs near two thousand clocks
  localparam int MCD = 4;
  localparam int RSTL = 4;
  localparam int PERIOD = 256 * 2 * MCD;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reloadWr = 1'b0;
  logic [7:0] reloadWrData = 8'h00;
  logic ctrlWr = 1'b0;
  logic ctrlWrStart = 1'b0;
  logic ctrlWrPresc = 1'b0;
  logic ctrlWrRetain = 1'b0;
  logic ctrlWrTimerMode = 1'b0;
  logic ctrlWrTimerRun = 1'b0;
  logic refreshWr = 1'b0;
  logic instrDone = 1'b0;
  logic ovfFlagClr = 1'b0;
  logic intSrcClr = 1'b0;
  logic timerInterruptEnable = 1'b0;
  logic idleMode = 1'b0;
  logic powerDown = 1'b0;
  logic peripheralPowerSave = 1'b0;
  logic [7:0] countHigh;
  logic [7:0] countLow;
  logic [7:0] reloadValue;
  logic prescSel;
  logic retainConfigBit;
  logic startBit;
  logic timerMode;
  logic timerRunBit;
  logic refreshBit;
  logic resetSrcFlag;
  logic timerOverflowFlag;
  logic interruptSourceBit;
  logic wdtSysReset;
  logic timerIrq;
  wire logic [15:0] cnt = {countHigh, countLow};
  wire logic [15:0] stat = {reloadValue, prescSel, retainConfigBit, startBit, timerMode, timerRunBit, refreshBit,
                            resetSrcFlag, timerOverflowFlag};
  wire logic [2:0] evts = {wdtSysReset, interruptSourceBit, timerIrq};
  logic [15:0] snap;
  int fails = 0;
  int checks = 0;
  int n;

  wdt_watchdog_timer #(.MC_DIV(MCD), .RST_LEN(RSTL)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reloadWr(reloadWr), .reloadWrData(reloadWrData), .ctrlWr(ctrlWr),
    .ctrlWrStart(ctrlWrStart), .ctrlWrPresc(ctrlWrPresc), .ctrlWrRetain(ctrlWrRetain),
    .ctrlWrTimerMode(ctrlWrTimerMode), .ctrlWrTimerRun(ctrlWrTimerRun), .refreshWr(refreshWr),
    .instrDone(instrDone), .ovfFlagClr(ovfFlagClr), .intSrcClr(intSrcClr),
    .timerInterruptEnable(timerInterruptEnable), .idleMode(idleMode), .powerDown(powerDown),
    .peripheralPowerSave(peripheralPowerSave), .countHigh(countHigh), .countLow(countLow),
    .reloadValue(reloadValue), .prescSel(prescSel), .retainConfigBit(retainConfigBit), .startBit(startBit),
    .timerMode(timerMode), .timerRunBit(timerRunBit), .refreshBit(refreshBit), .resetSrcFlag(resetSrcFlag),
    .timerOverflowFlag(timerOverflowFlag), .interruptSourceBit(interruptSourceBit), .wdtSysReset(wdtSysReset),
    .timerIrq(timerIrq)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic ctrl(input logic st, input logic pr, input logic rt, input logic tm, input logic tr);
    @(posedge sys_clk);
    ctrlWr <= 1'b1;
    ctrlWrStart <= st;
    ctrlWrPresc <= pr;
    ctrlWrRetain <= rt;
    ctrlWrTimerMode <= tm;
    ctrlWrTimerRun <= tr;
    @(posedge sys_clk);
    ctrlWr <= 1'b0;
    #1;
  endtask : ctrl

  // k instruction ends between the refresh write and the start write
  task automatic refresh(input int k);
    @(posedge sys_clk);
    refreshWr <= 1'b1;
    instrDone <= (k > 0);
    @(posedge sys_clk);
    refreshWr <= 1'b0;
    instrDone <= (k > 1);
    @(posedge sys_clk);
    instrDone <= 1'b0;
    ctrl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask : refresh

  task automatic resetCheck();
    check("count", 16'h0000, cnt);
    check("status", 16'h0000, stat);
    check("events", 16'h0000, {13'h0, evts});
  endtask : resetCheck

  task automatic freeze(input string name, input logic expMoving);
    cyc(2);
    snap = cnt;
    cyc(40);
    check(name, {15'h0, expMoving}, {15'h0, cnt !== snap});
    // hand back on an edge so the caller's next drive lands on it
    @(posedge sys_clk);
  endtask : freeze

  initial begin
    #(40000 * 25);
    fails++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(1);
    resetCheck();
    @(posedge sys_clk);
    reloadWr <= 1'b1;
    reloadWrData <= 8'hff;
    @(posedge sys_clk);
    reloadWr <= 1'b0;
    ctrl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    cyc(1);
    check("start load", 16'hff00, cnt);
    check("start status", 16'hff60, stat);
    ctrl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    check("no stop", 16'hff60, stat);
    @(posedge sys_clk);
    idleMode <= 1'b1;
    freeze("idle wdt", 1'b0);
    idleMode <= 1'b0;
    peripheralPowerSave <= 1'b1;
    freeze("peripheral_power_save wdt", 1'b1);
    peripheralPowerSave <= 1'b0;
    refresh(0);
    check("refresh armed", 16'h0001, {15'h0, refreshBit});
    cyc(1);
    check("no instr", 16'h0001, {15'h0, countLow !== 8'h00});
    refresh(2);
    cyc(1);
    check("two instr", 16'h0001, {15'h0, countLow !== 8'h00});
    cyc(12);
    check("refresh clear", 16'h0000, {15'h0, refreshBit});
    refresh(1);
    cyc(1);
    check("refresh load", 16'hff00, cnt);
    n = 0;
    while (wdtSysReset !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check("interval", 16'h0001, {15'h0, n >= PERIOD - 8 && n <= PERIOD + 8});
    check("wdt reset status", 16'hff62, stat);
    check("retained load", 16'hff00, cnt);
    n = 0;
    while (wdtSysReset === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("reset length", RSTL[15:0], n[15:0]);
    ctrl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    n = 0;
    while (cnt !== 16'hfffe && n < 3000) begin
      cyc(1);
      n++;
    end
    ctrl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    n = 0;
    // slow prescale needs about two 128-tick periods, over a thousand clocks
    while (wdtSysReset !== 1'b1 && n < 1200) begin
      cyc(1);
      n++;
    end
    check("unretained status", 16'h0022, stat);
    check("unretained load", 16'h0000, cnt);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(1);
    resetCheck();
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    check("timer mode", 16'h0010, stat);
    @(posedge sys_clk);
    reloadWr <= 1'b1;
    @(posedge sys_clk);
    reloadWr <= 1'b0;
    timerInterruptEnable <= 1'b1;
    ctrl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    check("scratch", 16'hff10, stat);
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(1);
    check("timer load", 16'hff00, cnt);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    check("mode locked", 16'hff18, stat);
    @(posedge sys_clk);
    peripheralPowerSave <= 1'b1;
    freeze("peripheral_power_save timer", 1'b0);
    peripheralPowerSave <= 1'b0;
    idleMode <= 1'b1;
    freeze("idle timer", 1'b1);
    idleMode <= 1'b0;
    powerDown <= 1'b1;
    freeze("power down", 1'b0);
    powerDown <= 1'b0;
    n = 0;
    while (timerOverflowFlag !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check("timer events", 16'h0003, {13'h0, evts});
    check("timer status", 16'hff19, stat);
    check("timer reload", 16'hff00, cnt);
    @(posedge sys_clk);
    timerInterruptEnable <= 1'b0;
    ovfFlagClr <= 1'b1;
    cyc(1);
    check("irq masked", 16'h0002, {13'h0, evts});
    check("flag cleared", 16'h0000, {15'h0, timerOverflowFlag});
    @(posedge sys_clk);
    ovfFlagClr <= 1'b0;
    intSrcClr <= 1'b1;
    @(posedge sys_clk);
    intSrcClr <= 1'b0;
    cyc(1);
    check("source cleared", 16'h0000, {13'h0, evts});
    n = 0;
    while (timerOverflowFlag !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    freeze("stopped", 1'b0);
    ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(1);
    check("restart", 16'hff18, stat);
    ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("stop and leave", 16'hff00, stat);
    complete_run();
  end
endmodule : wdt_watchdog_timer_tb
